/* hw/demod_frontend_config_regs.sv */
// configuration register bank and its direct effects for the demod front end
`timescale 1ns/1ps
`default_nettype none
`include "demod_cfg.svh"

// Behaviour
// RULE1: high aux pin: bit7 open drain, bit6 level
// RULE2: low aux pin: bit5 open drain, bit4 level
// RULE3: bits2:1 pick roll-off 35%/20%, rest reserved
// RULE4: bit0 negates Q after derotation
// RULE5: gain1 control bit7 enables dc compensation
// RULE6: software writes zero to gain1 bits 6:3
// RULE7: software keeps single reserved bits zero
// RULE8: reference bit7 complements tuner gain output
// RULE9: reference bits5:0 are first gain target
// RULE10: timing bits6:4 proportional, 2:0 integral
// RULE11: gain2 bits7:5 coefficient, 4:0 reference
module demod_frontend_config_regs
    import demod_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // register port from the control interface
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    output logic             o_reg_rvalid,
    // general-purpose pins (out / enable)
    output logic             o_aux_output_high_out,
    output logic             o_aux_output_high_oe,
    output logic             o_aux_output_low_out,
    output logic             o_aux_output_low_oe,
    // derotated samples in, sign-corrected samples out
    input  wire iq_sample_t  i_derot_sample,
    input  wire logic        i_derot_valid,
    output iq_sample_t       o_iq_sample,
    output logic             o_iq_valid,
    // gain control toward the tuner
    input  wire logic [7:0]  i_gain1_level,
    output logic      [7:0]  o_tuner_gain,
    // loop configuration
    output rolloff_t         o_rolloff,
    output gain1_cfg_t       o_gain1_cfg,
    output timing_cfg_t      o_timing_cfg,
    output gain2_cfg_t       o_gain2_cfg
);

    // ----------------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------------
    localparam logic [7:0] RST_VAL [`REG_COUNT] = '{
        `RST_OUTPUT_AND_FILTER_CONFIG,
        `RST_GAIN_LOOP1_CONTROL,
        `RST_TIMING_LOOP_COEFFICIENTS,
        `RST_GAIN_LOOP1_REFERENCE,
        `RST_GAIN_LOOP2_AND_OFFSET_CONTROL
    };

    logic [7:0] bank_reg [`REG_COUNT];  // index 0 sits at the base offset

    // address to bank index; out of range flagged, decoded for read and write
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - `OFS_OUTPUT_AND_FILTER_CONFIG;
        if (addr >= `OFS_OUTPUT_AND_FILTER_CONFIG &&
            addr <= `OFS_GAIN_LOOP2_AND_OFFSET_CONTROL) begin
            reg_index = {1'b0, rel[2:0]};
        end else begin
            reg_index = 4'h8;           // bit 3 marks unmapped
        end
    endfunction

    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    assign wr_idx = reg_index(i_reg_addr);
    assign rd_idx = reg_index(i_reg_addr);

    // one flop per register; all bits stored as written, software keeps
    // the must-be-zero bits clear, the logic never reads them
    genvar g;
    generate
        for (g = 0; g < `REG_COUNT; g++) begin : g_bank
            always_ff @(posedge i_ref_clk) begin
                if (!i_nrst) begin
                    bank_reg[g] <= RST_VAL[g];
                end else if (i_reg_wr && !wr_idx[3] &&
                             wr_idx[2:0] == 3'(g)) begin
                    bank_reg[g] <= i_reg_wdata;   // [RULE6] [RULE7]
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------------
    // read port: one cycle latency, unmapped offsets read zero
    // ----------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                // unmapped gives zero so a bad address is visible
                o_reg_rdata <= rd_idx[3] ? 8'h00 : bank_reg[rd_idx[2:0]];
            end
        end
    end

    // named views of the bank
    logic [7:0] io_cfg;
    logic [7:0] g1_ctl;
    logic [7:0] tmg_cfg;
    logic [7:0] g1_ref;
    logic [7:0] g2_ctl;
    assign io_cfg  = bank_reg[0];
    assign g1_ctl  = bank_reg[1];
    assign tmg_cfg = bank_reg[2];
    assign g1_ref  = bank_reg[3];
    assign g2_ctl  = bank_reg[4];

    // ----------------------------------------------------------------------
    // general-purpose pins
    // ----------------------------------------------------------------------
    // open drain only pulls low; a high level releases the pin
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_aux_output_high_out <= 1'b0;
            o_aux_output_high_oe  <= 1'b0;
            o_aux_output_low_out  <= 1'b0;
            o_aux_output_low_oe   <= 1'b0;
        end else begin
            if (io_cfg[`BIT_AUX_HIGH_OPEN_DRAIN]) begin        // [RULE1]
                o_aux_output_high_out <= 1'b0;
                o_aux_output_high_oe  <= !io_cfg[`BIT_AUX_HIGH_VALUE];
            end else begin                                     // [RULE1]
                o_aux_output_high_out <= io_cfg[`BIT_AUX_HIGH_VALUE];
                o_aux_output_high_oe  <= 1'b1;
            end
            if (io_cfg[`BIT_AUX_LOW_OPEN_DRAIN]) begin         // [RULE2]
                o_aux_output_low_out <= 1'b0;
                o_aux_output_low_oe  <= !io_cfg[`BIT_AUX_LOW_VALUE];
            end else begin                                     // [RULE2]
                o_aux_output_low_out <= io_cfg[`BIT_AUX_LOW_VALUE];
                o_aux_output_low_oe  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // roll-off selection
    // ----------------------------------------------------------------------
    // reserved codes are flagged rather than mapped, the filter sees them
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_rolloff <= ROLLOFF_35;
        end else begin
            case (io_cfg[`FLD_ROLLOFF_MSB:`FLD_ROLLOFF_LSB])
                2'b00:   o_rolloff <= ROLLOFF_35;              // [RULE3]
                2'b01:   o_rolloff <= ROLLOFF_20;              // [RULE3]
                default: o_rolloff <= ROLLOFF_RESERVED;        // [RULE3]
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // q sign correction after the derotator
    // ----------------------------------------------------------------------
    // -128 has no positive twin; saturate to +127 to avoid a sign flip
    function automatic logic [7:0] negate_sat(input logic [7:0] v);
        negate_sat = (v == 8'h80) ? 8'h7F : 8'(-v);
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_iq_sample <= '0;
            o_iq_valid  <= 1'b0;
        end else begin
            o_iq_valid <= i_derot_valid;
            if (i_derot_valid) begin
                o_iq_sample.i <= i_derot_sample.i;
                o_iq_sample.q <= io_cfg[`BIT_Q_NEGATE] ?
                                 negate_sat(i_derot_sample.q) : // [RULE4]
                                 i_derot_sample.q;
            end
        end
    end

    // ----------------------------------------------------------------------
    // tuner gain polarity
    // ----------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_tuner_gain <= 8'h00;
        end else if (g1_ref[`BIT_GAIN_INVERT]) begin
            o_tuner_gain <= ~i_gain1_level;                    // [RULE8]
        end else begin
            o_tuner_gain <= i_gain1_level;                     // [RULE8]
        end
    end

    // ----------------------------------------------------------------------
    // loop configuration outputs
    // ----------------------------------------------------------------------
    // registered copies keep every top output straight from a flop
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_gain1_cfg  <= '0;
            o_timing_cfg <= '0;
            o_gain2_cfg  <= '0;
        end else begin
            o_gain1_cfg.dc_comp_en <= g1_ctl[`BIT_DC_COMP_EN]; // [RULE5]
            o_gain1_cfg.first_gain_loop_coeff <=
                g1_ctl[`FLD_GAIN1_COEFF_MSB:`FLD_GAIN1_COEFF_LSB];
            o_gain1_cfg.first_gain_target <=
                g1_ref[`FLD_GAIN1_TARGET_MSB:`FLD_GAIN1_TARGET_LSB]; // [RULE9]
            o_timing_cfg.prop_coeff <=
                tmg_cfg[`FLD_TMG_PROP_MSB:`FLD_TMG_PROP_LSB];   // [RULE10]
            o_timing_cfg.integ_coeff <=
                tmg_cfg[`FLD_TMG_INTEG_MSB:`FLD_TMG_INTEG_LSB]; // [RULE10]
            o_gain2_cfg.coeff <=
                g2_ctl[`FLD_GAIN2_COEFF_MSB:`FLD_GAIN2_COEFF_LSB]; // [RULE11]
            o_gain2_cfg.second_gain_reference <=
                g2_ctl[`FLD_GAIN2_REF_MSB:`FLD_GAIN2_REF_LSB];  // [RULE11]
        end
    end

endmodule // demod_frontend_config_regs
`default_nettype wire

/* hw/demod_cfg.svh */
// offsets, field positions, reset values for the front-end configuration bank
`ifndef DEMOD_CFG_SVH
`define DEMOD_CFG_SVH

// --------------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------------
`define OFS_OUTPUT_AND_FILTER_CONFIG      8'h0C
`define OFS_GAIN_LOOP1_CONTROL            8'h0D
`define OFS_TIMING_LOOP_COEFFICIENTS      8'h0E
`define OFS_GAIN_LOOP1_REFERENCE          8'h0F
`define OFS_GAIN_LOOP2_AND_OFFSET_CONTROL 8'h10
`define REG_COUNT                         5

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define RST_OUTPUT_AND_FILTER_CONFIG      8'hF0
`define RST_GAIN_LOOP1_CONTROL            8'h81
`define RST_TIMING_LOOP_COEFFICIENTS      8'h23
`define RST_GAIN_LOOP1_REFERENCE          8'h54
`define RST_GAIN_LOOP2_AND_OFFSET_CONTROL 8'h74

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define BIT_AUX_HIGH_OPEN_DRAIN 7
`define BIT_AUX_HIGH_VALUE      6
`define BIT_AUX_LOW_OPEN_DRAIN  5
`define BIT_AUX_LOW_VALUE       4
`define FLD_ROLLOFF_MSB         2
`define FLD_ROLLOFF_LSB         1
`define BIT_Q_NEGATE            0
`define BIT_DC_COMP_EN          7
`define FLD_GAIN1_COEFF_MSB     2
`define FLD_GAIN1_COEFF_LSB     0
`define FLD_TMG_PROP_MSB        6
`define FLD_TMG_PROP_LSB        4
`define FLD_TMG_INTEG_MSB       2
`define FLD_TMG_INTEG_LSB       0
`define BIT_GAIN_INVERT         7
`define FLD_GAIN1_TARGET_MSB    5
`define FLD_GAIN1_TARGET_LSB    0
`define FLD_GAIN2_COEFF_MSB     7
`define FLD_GAIN2_COEFF_LSB     5
`define FLD_GAIN2_REF_MSB       4
`define FLD_GAIN2_REF_LSB       0

`endif

/* hw/demod_pkg.sv */
// types shared by the front-end configuration bank
`default_nettype none
package demod_pkg;

    // ----------------------------------------------------------------------
    // roll-off selection, one-hot, reserved codes flagged separately
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        ROLLOFF_35       = 3'b001,
        ROLLOFF_20       = 3'b010,
        ROLLOFF_RESERVED = 3'b100
    } rolloff_t;

    // ----------------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] i;  // in-phase, signed
        logic [7:0] q;  // quadrature, signed
    } iq_sample_t;

    typedef struct packed {
        logic       dc_comp_en;          // dc offset compensation on
        logic [2:0] first_gain_loop_coeff;
        logic [5:0] first_gain_target;
    } gain1_cfg_t;

    typedef struct packed {
        logic [2:0] prop_coeff;          // proportional coefficient
        logic [2:0] integ_coeff;         // integral coefficient
    } timing_cfg_t;

    typedef struct packed {
        logic [2:0] coeff;               // second loop coefficient
        logic [4:0] second_gain_reference;
    } gain2_cfg_t;

endpackage : demod_pkg
`default_nettype wire

/* testbench/tuner_model.sv */
// behavioural tuner fed by the gain control word
`timescale 1ns/1ps
`default_nettype none
module tuner_model (
    // clock
    input  wire logic       i_ref_clk,
    // control word in, gain applied out
    input  wire logic [7:0] i_gain_ctrl,
    output logic      [7:0] o_applied_gain
);
    // gain settles one clock after the control word moves
    always_ff @(posedge i_ref_clk) begin
        o_applied_gain <= i_gain_ctrl;
    end
endmodule // tuner_model
`default_nettype wire

/* testbench/demod_frontend_config_regs_assertions.sv */
// port-level assertions for the front-end configuration bank
`timescale 1ns/1ps
`default_nettype none
module demod_cfg_checker
    import demod_pkg::*;
(
    input wire logic       i_ref_clk,
    input wire logic       i_nrst,
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       o_aux_output_high_out,
    input wire logic       o_aux_output_high_oe,
    input wire logic       o_aux_output_low_out,
    input wire logic       o_aux_output_low_oe,
    input wire iq_sample_t i_derot_sample,
    input wire logic       i_derot_valid,
    input wire iq_sample_t o_iq_sample,
    input wire logic       o_iq_valid,
    input wire logic [7:0] i_gain1_level,
    input wire logic [7:0] o_tuner_gain,
    input wire rolloff_t   o_rolloff,
    input wire gain1_cfg_t o_gain1_cfg,
    input wire timing_cfg_t o_timing_cfg,
    input wire gain2_cfg_t o_gain2_cfg
);
    // ----------------------------------------------------------------
    // helpers: write data two cycles back, shadow sign/invert bits
    // ----------------------------------------------------------------
    logic [7:0] wd1, wd2;
    logic       qneg, inv;
    function automatic logic w(input logic [7:0] a);
        return i_reg_wr && i_reg_addr == a;
    endfunction
    function automatic logic [7:0] negq(input logic [7:0] q);
        return q == 8'h80 ? 8'h7F : 8'h00 - q; // -128 saturates
    endfunction
    always_ff @(posedge i_ref_clk) begin
        wd1 <= i_reg_wdata;
        wd2 <= wd1;
    end
    // shadows follow writes; reset values have both bits clear
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            qneg <= 1'b0;
            inv <= 1'b0;
        end else begin
            if (w(8'h0C)) qneg <= i_reg_wdata[0];
            if (w(8'h0F)) inv <= i_reg_wdata[7];
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_high_pin_drive: assert property (
        w(8'h0C) |-> ##2 o_aux_output_high_oe == !(wd2[7] && wd2[6])
        && o_aux_output_high_out == (!wd2[7] && wd2[6]))
        else $error("high aux pin drive wrong");
    a_low_pin_drive: assert property (
        w(8'h0C) |-> ##2 o_aux_output_low_oe == !(wd2[5] && wd2[4])
        && o_aux_output_low_out == (!wd2[5] && wd2[4]))
        else $error("low aux pin drive wrong");
    a_rolloff_select: assert property (
        w(8'h0C) |-> ##2 o_rolloff == (wd2[2:1] == 2'b00 ? ROLLOFF_35 :
        wd2[2:1] == 2'b01 ? ROLLOFF_20 : ROLLOFF_RESERVED))
        else $error("rolloff select wrong");
    a_q_sign_fix: assert property (
        $past(i_derot_valid) && $past(i_nrst) && $past(qneg) ==
        $past(qneg, 2) |-> o_iq_valid && o_iq_sample.i ==
        $past(i_derot_sample.i) && o_iq_sample.q == ($past(qneg) ?
        negq($past(i_derot_sample.q)) : $past(i_derot_sample.q)))
        else $error("q sample sign wrong");
    a_dc_comp_coeff: assert property (
        w(8'h0D) |-> ##2 o_gain1_cfg.dc_comp_en == wd2[7]
        && o_gain1_cfg.first_gain_loop_coeff == wd2[2:0])
        else $error("gain1 control fields wrong");
    a_tuner_polarity: assert property (
        $past(i_nrst) && $past(inv) == $past(inv, 2) |-> o_tuner_gain ==
        ($past(inv) ? ~$past(i_gain1_level) : $past(i_gain1_level)))
        else $error("tuner gain polarity wrong");
    a_gain1_target: assert property (
        w(8'h0F) |-> ##2 o_gain1_cfg.first_gain_target == wd2[5:0])
        else $error("gain1 target wrong");
    a_timing_coeffs: assert property (
        w(8'h0E) |-> ##2 o_timing_cfg == {wd2[6:4], wd2[2:0]})
        else $error("timing coefficients wrong");
    a_gain2_fields: assert property (
        w(8'h10) |-> ##2 o_gain2_cfg == wd2)
        else $error("gain2 fields wrong");
    // main scenarios reached
    c_open_drain: cover property (w(8'h0C) ##2 !o_aux_output_high_oe);
    c_q_negated: cover property (qneg && o_iq_valid);
    c_inverted: cover property (inv && o_tuner_gain != 8'h00);
endmodule // demod_cfg_checker
bind demod_frontend_config_regs demod_cfg_checker u_demod_cfg_checker (
    .i_ref_clk             (i_ref_clk),
    .i_nrst                (i_nrst),
    .i_reg_wr              (i_reg_wr),
    .i_reg_addr            (i_reg_addr),
    .i_reg_wdata           (i_reg_wdata),
    .o_aux_output_high_out (o_aux_output_high_out),
    .o_aux_output_high_oe  (o_aux_output_high_oe),
    .o_aux_output_low_out  (o_aux_output_low_out),
    .o_aux_output_low_oe   (o_aux_output_low_oe),
    .i_derot_sample        (i_derot_sample),
    .i_derot_valid         (i_derot_valid),
    .o_iq_sample           (o_iq_sample),
    .o_iq_valid            (o_iq_valid),
    .i_gain1_level         (i_gain1_level),
    .o_tuner_gain          (o_tuner_gain),
    .o_rolloff             (o_rolloff),
    .o_gain1_cfg           (o_gain1_cfg),
    .o_timing_cfg          (o_timing_cfg),
    .o_gain2_cfg           (o_gain2_cfg)
);
`default_nettype wire

/* testbench/demod_frontend_config_regs_tb_top.sv */
// self-checking bench for the front-end configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "demod_cfg.svh"
module demod_frontend_config_regs_tb_top
    import demod_pkg::*;
;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, dv = 1'b0;
    logic [7:0]  addr = 8'h00, wdat = 8'h00, lvl = 8'h00, rdat, tg, app;
    iq_sample_t  ds = 16'h0000, iq;
    logic        rv, hio, hie, loo, loe, iqv;
    rolloff_t    ro;
    gain1_cfg_t  g1;
    timing_cfg_t tc;
    gain2_cfg_t  g2;
    int          err_total = 0, checks_done = 0, cycles = 0;
    demod_frontend_config_regs u_demod_frontend_config_regs (
        .i_ref_clk(clk), .i_nrst(nrst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdat),
        .o_reg_rvalid(rv), .o_aux_output_high_out(hio),
        .o_aux_output_high_oe(hie), .o_aux_output_low_out(loo),
        .o_aux_output_low_oe(loe), .i_derot_sample(ds), .i_derot_valid(dv),
        .o_iq_sample(iq), .o_iq_valid(iqv), .i_gain1_level(lvl),
        .o_tuner_gain(tg), .o_rolloff(ro), .o_gain1_cfg(g1),
        .o_timing_cfg(tc), .o_gain2_cfg(g2));
    tuner_model u_tuner_model (.i_ref_clk(clk), .i_gain_ctrl(tg),
        .o_applied_gain(app));
    always #10 clk = ~clk;
    // hang guard; the whole run needs under 150 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one-cycle strobes, raised just after an edge
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #1;
        wr = 1'b1;
        addr = a;
        wdat = d;
        @(posedge clk); #1;
        wr = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk); #1;
        rd = 1'b1;
        addr = a;
        @(posedge clk); #1;
        rd = 1'b0;
        chk({15'h0000, rv}, 16'h0001);
        chk({8'h00, rdat}, {8'h00, exp});
    endtask
    task automatic smp(input logic [15:0] s, input logic [15:0] exp);
        @(posedge clk); #1;
        ds = s;
        dv = 1'b1;
        @(posedge clk); #1;
        dv = 1'b0;
        chk({15'h0000, iqv}, 16'h0001);
        chk(iq, exp);
    endtask
    // derived outputs trail the register by one edge
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        rdc(8'h0C, `RST_OUTPUT_AND_FILTER_CONFIG);
        rdc(8'h0D, `RST_GAIN_LOOP1_CONTROL);
        rdc(8'h0E, `RST_TIMING_LOOP_COEFFICIENTS);
        rdc(8'h0F, `RST_GAIN_LOOP1_REFERENCE);
        rdc(8'h10, `RST_GAIN_LOOP2_AND_OFFSET_CONTROL);
        chk({hio, hie, loo, loe}, 4'b0000);
        chk(ro, ROLLOFF_35);
        chk(g1, {1'b1, 3'h1, 6'h14});
        chk(tc, {3'h2, 3'h3});
        chk(g2, {3'h3, 5'h14});
        $display("test reset done");
    endtask
    // every pin mode and level, both legal filter codes; software keeps
    // the reserved roll-off codes out of the register
    task automatic t_pins;
        logic [3:0] m;
        for (int n = 0; n < 16; n++) begin
            m = 4'(n);
            wrr(8'h0C, {m, 1'b0, 1'b0, m[0], 1'b0});
            settle();
            chk({hio, hie}, {!m[3] && m[2], !(m[3] && m[2])});
            chk({loo, loe}, {!m[1] && m[0], !(m[1] && m[0])});
            chk(ro, m[0] ? ROLLOFF_20 : ROLLOFF_35);
        end
        $display("test pins done");
    endtask
    task automatic t_qneg;
        wrr(8'h0C, 8'h01);
        settle();
        smp(16'h1205, 16'h12FB);
        smp(16'h3480, 16'h347F);
        wrr(8'h0C, 8'h00);
        settle();
        smp(16'h5680, 16'h5680);
        $display("test qneg done");
    endtask
    task automatic t_loops;
        wrr(8'h0D, 8'h06);
        wrr(8'h0E, 8'h75);
        wrr(8'h0F, 8'h2A);
        wrr(8'h10, 8'hA9);
        wrr(8'h11, 8'hFF);
        settle();
        chk(g1, {1'b0, 3'h6, 6'h2A});
        chk(tc, {3'h7, 3'h5});
        chk(g2, {3'h5, 5'h09});
        rdc(8'h11, 8'h00);
        rdc(8'h10, 8'hA9);
        $display("test loops done");
    endtask
    // tuner sees the control word one clock after the bank drives it
    task automatic t_tuner;
        wrr(8'h0F, 8'hAA);
        settle();
        lvl = 8'h3C;
        settle();
        chk(app, 8'hC3);
        wrr(8'h0F, 8'h2A);
        settle();
        settle();
        chk(app, 8'h3C);
        $display("test tuner done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_pins();
        t_qneg();
        t_loops();
        t_tuner();
        conclude();
    end
endmodule // demod_frontend_config_regs_tb_top
`default_nettype wire
